// >>> pkg/pwmts_pkg.sv
// Package for the PWM trip source selection block.
// Assumes an AHB-Lite register bus with 32-bit data and one clock.
package pwmts_pkg;
  localparam int          NUM_PINS     = 6;
  // Register byte offsets.
  localparam logic [11:0] OFF_SELECT   = 12'h000;
  localparam logic [11:0] OFF_ACTION   = 12'h004;
  localparam logic [11:0] OFF_IRQEN    = 12'h008;
  localparam logic [11:0] OFF_FLAGS    = 12'h00C;
  localparam logic [11:0] OFF_CLEAR    = 12'h010;
  // Select register layout.
  localparam int          POS_CYCLE    = 0;
  localparam int          POS_ONESHOT  = 8;
  localparam logic [15:0] SELECT_MASK  = 16'h3F3F;
  localparam logic [15:0] SELECT_RESET = 16'h0000;
  // Action register layout.
  localparam int          POS_ACT_A    = 0;
  localparam int          POS_ACT_B    = 2;
  localparam logic [3:0]  ACTION_RESET = 4'h0;
  // Interrupt enable, flag and clear bit positions.
  localparam int          POS_INT      = 0;
  localparam int          POS_CBC      = 1;
  localparam int          POS_OST      = 2;
  localparam logic [2:0]  IRQEN_RESET  = 3'h0;
  // Trip action encodings.
  localparam logic [1:0]  ACT_HIZ      = 2'h0;
  localparam logic [1:0]  ACT_HIGH     = 2'h1;
  localparam logic [1:0]  ACT_LOW      = 2'h2;
  localparam logic [1:0]  ACT_NONE     = 2'h3;
endpackage : pwmts_pkg

// >>> rtl/pwmts_out_stage.sv
// Output stage that applies a trip action to one PWM output.
// Assumes a clean PWM level from the action logic upstream.
module pwmts_out_stage (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       resetn,
  // Control.
  input  wire logic       tripActive,
  input  wire logic [1:0] action,
  input  wire logic       pwmIn,
  // Pin.
  output logic            pinOut,
  output logic            pinOe
);
  logic outNxt;
  logic oeNxt;

  assign outNxt = !tripActive ? pwmIn :
                  (action == pwmts_pkg::ACT_HIGH) ? 1'b1 :
                  (action == pwmts_pkg::ACT_LOW)  ? 1'b0 : pwmIn;
  assign oeNxt  = !(tripActive && action == pwmts_pkg::ACT_HIZ);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end else begin
      pinOut <= outNxt;
      pinOe  <= oeNxt;
    end
  end

  chk_hiz_on_trip: assert property (
    @(posedge clk) disable iff (!resetn)
    (tripActive && action == pwmts_pkg::ACT_HIZ) |=> !pinOe)
    else $error("Output drove during high impedance trip.");
endmodule : pwmts_out_stage

// >>> rtl/pwmts_trip_select.sv
// Trip source selection with latched one-shot and cycle trips.
// Assumes active-low asynchronous fault pins and a same-clock counter-zero
// strobe from the time base.
// Contract
// - One-shot enables at bits 13:8, pins 6..1.
// - Cycle enables at bits 5:0, pins 6..1.
// - Cleared enable ignores that pin for that type.
// - Enabled low pin raises one-shot trip.
// - One-shot trip applies action to both outputs.
// - One-shot stays latched until software clear.
// - Cycle trip acts; clears at counter zero.
// - Reset selects zero; reserved bits read zero.
// - Action codes: hiz, high, low, unchanged.
// - Enabled trip events raise trip interrupt.
//
// Our own choices: register access over AHB-Lite and the register offsets.
module pwmts_trip_select (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        resetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Fault pins, active low.
  input  wire logic [5:0]  faultPinN,
  // Time base and PWM.
  input  wire logic        counterZero,
  input  wire logic        pwmInA,
  input  wire logic        pwmInB,
  output logic             pwmOutA,
  output logic             pwmOutAOe,
  output logic             pwmOutB,
  output logic             pwmOutBOe,
  // Status.
  output logic             tripIrq
);
  localparam int N = pwmts_pkg::NUM_PINS;

  logic [5:0]  pinS1_r, pinS2_r;
  logic [15:0] select_r;
  logic [3:0]  action_r;
  logic [2:0]  irqEn_r;
  logic        oneShot_r, cycle_r, irqFlag_r;
  logic        wrPend_r;
  logic [11:0] wrAddr_r;
  logic [31:0] rdData_nxt;

  wire [5:0] pinLow    = ~pinS2_r;
  wire [5:0] oneShotEn = select_r[pwmts_pkg::POS_ONESHOT +: N];
  wire [5:0] cycleEn   = select_r[pwmts_pkg::POS_CYCLE +: N];
  wire oneShotEvt = |(pinLow & oneShotEn);
  wire cycleEvt   = |(pinLow & cycleEn);

  wire addrPhase = hsel && hready && htrans[1];
  wire wrSelect  = wrPend_r && wrAddr_r == pwmts_pkg::OFF_SELECT;
  wire wrAction  = wrPend_r && wrAddr_r == pwmts_pkg::OFF_ACTION;
  wire wrIrqEn   = wrPend_r && wrAddr_r == pwmts_pkg::OFF_IRQEN;
  wire wrClear   = wrPend_r && wrAddr_r == pwmts_pkg::OFF_CLEAR;
  wire clrOst = wrClear && hwdata[pwmts_pkg::POS_OST];
  wire clrCbc = wrClear && hwdata[pwmts_pkg::POS_CBC];
  wire clrInt = wrClear && hwdata[pwmts_pkg::POS_INT];
  wire irqEvt = (oneShotEvt && irqEn_r[pwmts_pkg::POS_OST]) ||
                (cycleEvt && irqEn_r[pwmts_pkg::POS_CBC]);
  wire tripActive = oneShot_r || cycle_r;

  // Pins come from outside, so they pass two flip-flops first.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinS1_r <= 6'h3F;
      pinS2_r <= 6'h3F;
    end else begin
      pinS1_r <= faultPinN;
      pinS2_r <= pinS1_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 12'h000;
    end else begin
      wrPend_r <= addrPhase && hwrite;
      wrAddr_r <= {haddr[11:2], 2'b00};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      select_r <= pwmts_pkg::SELECT_RESET;
      action_r <= pwmts_pkg::ACTION_RESET;
      irqEn_r  <= pwmts_pkg::IRQEN_RESET;
    end else begin
      if (wrSelect)
        select_r <= hwdata[15:0] & pwmts_pkg::SELECT_MASK;
      if (wrAction)
        action_r <= hwdata[3:0];
      if (wrIrqEn)
        irqEn_r <= {hwdata[2:1], 1'b0};
    end
  end

  // A new trip in the clearing cycle wins over the clear.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oneShot_r <= 1'b0;
      cycle_r   <= 1'b0;
      irqFlag_r <= 1'b0;
    end else begin
      oneShot_r <= oneShotEvt || (oneShot_r && !clrOst);
      cycle_r   <= cycleEvt || (cycle_r && !counterZero && !clrCbc);
      irqFlag_r <= irqEvt || (irqFlag_r && !clrInt);
    end
  end

  always_comb begin
    rdData_nxt = 32'h0000_0000;
    unique case (haddr[11:2])
      pwmts_pkg::OFF_SELECT[11:2]: rdData_nxt[15:0] = select_r;
      pwmts_pkg::OFF_ACTION[11:2]: rdData_nxt[3:0]  = action_r;
      pwmts_pkg::OFF_IRQEN[11:2]:  rdData_nxt[2:0]  = irqEn_r;
      pwmts_pkg::OFF_FLAGS[11:2]:
        rdData_nxt[2:0] = {oneShot_r, cycle_r, irqFlag_r};
      default:                     rdData_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      hrdata <= 32'h0000_0000;
    else if (addrPhase && !hwrite)
      hrdata <= rdData_nxt;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign tripIrq   = irqFlag_r;

  pwmts_out_stage uStageA (
    .clk        (clk),
    .resetn     (resetn),
    .tripActive (tripActive),
    .action     (action_r[pwmts_pkg::POS_ACT_A +: 2]),
    .pwmIn      (pwmInA),
    .pinOut     (pwmOutA),
    .pinOe      (pwmOutAOe)
  );

  pwmts_out_stage uStageB (
    .clk        (clk),
    .resetn     (resetn),
    .tripActive (tripActive),
    .action     (action_r[pwmts_pkg::POS_ACT_B +: 2]),
    .pwmIn      (pwmInB),
    .pinOut     (pwmOutB),
    .pinOe      (pwmOutBOe)
  );

  chk_oneshot_latch: assert property (
    @(posedge clk) disable iff (!resetn)
    (oneShot_r && !clrOst) |=> oneShot_r)
    else $error("One-shot trip released without clear.");
  chk_oneshot_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    (oneShot_r && clrOst && !oneShotEvt) |=> !oneShot_r)
    else $error("One-shot trip survived its clear.");
  chk_oneshot_raise: assert property (
    @(posedge clk) disable iff (!resetn)
    oneShotEvt |=> oneShot_r)
    else $error("Enabled low pin did not raise one-shot trip.");
  chk_cycle_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    (counterZero && !cycleEvt) |=> !cycle_r)
    else $error("Cycle trip survived counter zero.");
  chk_cycle_reassert: assert property (
    @(posedge clk) disable iff (!resetn)
    (counterZero && cycleEvt) |=> cycle_r)
    else $error("Cycle trip not reasserted.");
  chk_cycle_action: assert property (
    @(posedge clk) disable iff (!resetn)
    (cycle_r && action_r[pwmts_pkg::POS_ACT_A +: 2] == pwmts_pkg::ACT_LOW)
    |=> (pwmOutAOe && !pwmOutA))
    else $error("Cycle trip action not applied.");
  chk_ignore_disabled: assert property (
    @(posedge clk) disable iff (!resetn)
    (select_r == 16'h0000 && !oneShot_r && !clrOst) |=> !oneShot_r)
    else $error("Disabled pin caused a trip.");
  chk_cycle_ignore: assert property (
    @(posedge clk) disable iff (!resetn)
    (!(|(pinLow & cycleEn)) && !cycle_r) |=> !cycle_r)
    else $error("Disabled pin caused a cycle trip.");
  chk_reserved_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    (select_r & ~pwmts_pkg::SELECT_MASK) == 16'h0000)
    else $error("Reserved select bits set.");
  chk_both_outputs: assert property (
    @(posedge clk) disable iff (!resetn)
    (oneShot_r && action_r == {pwmts_pkg::ACT_HIGH, pwmts_pkg::ACT_LOW})
    |=> (pwmOutAOe && !pwmOutA && pwmOutBOe && pwmOutB))
    else $error("Trip action not applied to both outputs.");
  chk_irq_raise: assert property (
    @(posedge clk) disable iff (!resetn)
    (cycleEvt && irqEn_r[pwmts_pkg::POS_CBC]) |=> tripIrq)
    else $error("Enabled cycle trip gave no interrupt.");
  chk_irq_oneshot: assert property (
    @(posedge clk) disable iff (!resetn)
    (oneShotEvt && irqEn_r[pwmts_pkg::POS_OST]) |=> tripIrq)
    else $error("Enabled one-shot trip gave no interrupt.");
  chk_dual_source: assert property (
    @(posedge clk) disable iff (!resetn)
    (|(pinLow & oneShotEn & cycleEn)) |=> (oneShot_r && cycle_r))
    else $error("Dual source did not raise both trips.");
  chk_sel_write: assert property (
    @(posedge clk) disable iff (!resetn)
    wrSelect |=> select_r == ($past(hwdata[15:0]) & pwmts_pkg::SELECT_MASK))
    else $error("Select write not stored.");

  cov_oneshot: cover property (@(posedge clk) disable iff (!resetn)
    oneShotEvt ##[1:20] clrOst);
  cov_cycle: cover property (@(posedge clk) disable iff (!resetn)
    cycle_r ##1 counterZero ##1 !cycle_r);
  cov_irq: cover property (@(posedge clk) disable iff (!resetn)
    tripIrq ##[1:20] !tripIrq);
  cov_dual: cover property (@(posedge clk) disable iff (!resetn)
    oneShot_r && cycle_r);
  cov_hiz: cover property (@(posedge clk) disable iff (!resetn)
    tripActive && !pwmOutAOe);
endmodule : pwmts_trip_select

// >>> verification/pwmts_fault_src.sv
// Model of the external fault sources on the six trip pins.
// Assumes pull-ups on the pins, so a released pin reads high.
module pwmts_fault_src (
  // Requests from the bench, one per pin.
  input  wire logic [5:0] lowReq,
  // Pins, active low.
  output logic      [5:0] faultPinN
);
  timeunit 1ns;
  timeprecision 1ps;
  assign faultPinN = ~lowReq;
endmodule : pwmts_fault_src

// >>> verification/tb_pwm_trip_source_select.sv
// Self-checking bench for the trip source selection block.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
module tb_pwm_trip_source_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, resetn = 0, hsel = 0, hwrite = 0, counterZero = 0;
  logic        pwmInA = 1, pwmInB = 0, rdPhase = 0, outChk = 0, busPhase = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [5:0]  lowReq = 6'h00, faultPinN;
  logic        hreadyout, hresp, pwmOutA, pwmOutAOe, pwmOutB, pwmOutBOe;
  logic        tripIrq;
  logic [31:0] rdQ[$];
  logic [3:0]  outQ[$];
  logic        respQ[$], irqQ[$];
  int          badCount = 0, numChecks = 0, pin, code;
  pwmts_fault_src src (.lowReq(lowReq), .faultPinN(faultPinN));
  pwmts_trip_select uut (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .faultPinN(faultPinN),
    .counterZero(counterZero), .pwmInA(pwmInA), .pwmInB(pwmInB),
    .pwmOutA(pwmOutA), .pwmOutAOe(pwmOutAOe), .pwmOutB(pwmOutB),
    .pwmOutBOe(pwmOutBOe), .tripIrq(tripIrq));
  always #4 clk = ~clk;
  task automatic closeOut();
    if (badCount == 0 && numChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : closeOut
  task automatic cmpWord(logic [31:0] e, logic [31:0] s);
    numChecks++;
    if (s !== e) begin
      badCount++;
      $display("Error hrdata expected %h seen %h", e, s);
    end
  endtask : cmpWord
  task automatic cmpOut(logic [3:0] e, logic [3:0] s);
    numChecks++;
    if (s !== e) begin
      badCount++;
      $display("Error pwm outputs expected %b seen %b", e, s);
    end
  endtask : cmpOut
  task automatic cmpBit(string n, logic e, logic s);
    numChecks++;
    if (s !== e) begin
      badCount++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask : cmpBit
  // A driven-off output has no defined level, so its value is masked.
  always @(posedge clk) begin
    if (rdPhase && hreadyout === 1'b1) cmpWord(rdQ.pop_front(), hrdata);
    if (busPhase && hreadyout === 1'b1)
      cmpBit("hresp", respQ.pop_front(), hresp);
    if (outChk) begin
      cmpOut(outQ.pop_front(), {pwmOutAOe, pwmOutAOe & pwmOutA,
        pwmOutBOe, pwmOutBOe & pwmOutB});
      cmpBit("tripIrq", irqQ.pop_front(), tripIrq);
    end
  end
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      badCount++;
      closeOut();
    end
  endtask : waitReady
  task automatic busOp(logic wr, logic [11:0] a, logic [31:0] d,
                       logic [31:0] e);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr) rdQ.push_back(e);
    respQ.push_back(1'b0);
    rdPhase <= !wr;
    busPhase <= 1'b1;
    waitReady();
    rdPhase <= 1'b0;
    busPhase <= 1'b0;
  endtask : busOp
  task automatic chkOut(logic [3:0] e, logic irq);
    outQ.push_back(e);
    irqQ.push_back(irq);
    outChk <= 1'b1;
    @(posedge clk);
    outChk <= 1'b0;
  endtask : chkOut
  task automatic pulseZero();
    counterZero <= 1'b1;
    @(posedge clk);
    counterZero <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulseZero
  function automatic logic [1:0] actOut(logic [1:0] c, logic p);
    case (c)
      pwmts_pkg::ACT_HIZ:  return 2'h0;
      pwmts_pkg::ACT_HIGH: return 2'h3;
      pwmts_pkg::ACT_LOW:  return 2'h2;
      default:             return {1'b1, p};
    endcase
  endfunction : actOut
  initial begin
    void'($urandom(32'h6A76));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    busOp(0, pwmts_pkg::OFF_SELECT, 0, 32'h0);
    busOp(1, pwmts_pkg::OFF_SELECT, 32'hFFFFFFFF, 0);
    busOp(0, pwmts_pkg::OFF_SELECT, 0, 32'h00003F3F);
    busOp(0, 12'h020, 0, 32'h0);
    for (code = 0; code < 4; code++) begin
      pin = $urandom_range(5, 0);
      pwmInA <= 1'($urandom);
      pwmInB <= 1'($urandom);
      busOp(1, pwmts_pkg::OFF_SELECT, 32'h1 << pin, 0);
      busOp(1, pwmts_pkg::OFF_ACTION, {28'h0, code[1:0], code[1:0]}, 0);
      lowReq <= 6'h3F & ~(6'h1 << pin);
      repeat (6) @(posedge clk);
      chkOut({1'b1, pwmInA, 1'b1, pwmInB}, 1'b0);
      lowReq <= 6'h1 << pin;
      repeat (6) @(posedge clk);
      chkOut({actOut(code[1:0], pwmInA), actOut(code[1:0], pwmInB)},
             1'b0);
      pulseZero();
      chkOut({actOut(code[1:0], pwmInA), actOut(code[1:0], pwmInB)},
             1'b0);
      lowReq <= 6'h00;
      repeat (6) @(posedge clk);
      chkOut({actOut(code[1:0], pwmInA), actOut(code[1:0], pwmInB)},
             1'b0);
      pulseZero();
      chkOut({1'b1, pwmInA, 1'b1, pwmInB}, 1'b0);
    end
    pin = $urandom_range(5, 0);
    busOp(1, pwmts_pkg::OFF_ACTION, 32'h6, 0);
    busOp(1, pwmts_pkg::OFF_IRQEN, 32'h6, 0);
    busOp(1, pwmts_pkg::OFF_SELECT, 32'h101 << pin, 0);
    lowReq <= 6'h1 << pin;
    repeat (6) @(posedge clk);
    chkOut(4'hB, 1'b1);
    lowReq <= 6'h00;
    repeat (6) @(posedge clk);
    pulseZero();
    chkOut(4'hB, 1'b1);
    busOp(0, pwmts_pkg::OFF_FLAGS, 0, 32'h5);
    busOp(1, pwmts_pkg::OFF_CLEAR, 32'h7, 0);
    repeat (5) @(posedge clk);
    chkOut({1'b1, pwmInA, 1'b1, pwmInB}, 1'b0);
    busOp(0, pwmts_pkg::OFF_FLAGS, 0, 32'h0);
    repeat (2) @(posedge clk);
    closeOut();
  end
endmodule : tb_pwm_trip_source_select
